// *** rtl/sub_store_defs.vh ***
// shared constants for the subtract and word store unit
`ifndef SUB_STORE_DEFS_VH
`define SUB_STORE_DEFS_VH
// ****************************************************************
// register map (word addresses, one per register)
// ****************************************************************
`define OFS_CTRL      4'h0
`define OFS_OPCODE    4'h1
`define OFS_OP_A      4'h2
`define OFS_OP_B      4'h3
`define OFS_BASE_LO   4'h4
`define OFS_BASE_HI   4'h5
`define OFS_AMR       4'h6
`define OFS_RES_LO    4'h7
`define OFS_RES_HI    4'h8
`define OFS_MEM_ADDR  4'h9
`define OFS_MEM_DATA  4'hA
`define OFS_WB_BASE   4'hB
`define OFS_STATUS    4'hC
// ****************************************************************
// operation codes (opcode register bits 3:0)
// ****************************************************************
`define OP_SUB_LS     4'h0
`define OP_SUB_LONG   4'h1
`define OP_SUB_D      4'h2
`define OP_SUBA_B     4'h3
`define OP_SUBA_H     4'h4
`define OP_SUBA_W     4'h5
`define OP_COND_SUBTRACT_SHIFT_OP       4'h6
`define OP_STW_REG    4'h7
`define OP_STW_LONG   4'h8
// ****************************************************************
// opcode register fields
// ****************************************************************
`define F_OP_LO       0
`define F_OP_HI       3
`define F_CONST_A     4
`define F_CONST_B     5
`define F_SIDE_S      6
`define F_SIDE_Y      7
`define F_UNIT_D2     8
`define F_PRED        9
`define F_CIRC_BASE   10
`define F_MODE_LO     11
`define F_MODE_HI     13
`define F_OFS15_LO    16
`define F_OFS15_HI    30
// addressing modes for the register-offset store
`define AM_POST_INC   3'h0
`define AM_POST_DEC   3'h1
`define AM_PRE_INC    3'h2
`define AM_PRE_DEC    3'h3
`define AM_POS_OFS    3'h4
`define AM_NEG_OFS    3'h5
// ****************************************************************
// status bits
// ****************************************************************
`define ST_DONE       0
`define ST_SKIPPED    1
`define ST_ALIGN_ERR  2
`define ST_UNIT_ERR   3
`define ST_STORED     4
`define ST_SRC_B      5
// fixed answer latency for read, in cycles
`define RD_LATENCY    2'h1
`define RST_ZERO      32'h00000000
`endif

// *** rtl/operand_select.v ***
// operand preparation: 5-bit constants or register values
`timescale 1ns/100ps
`default_nettype none
module operand_select (
  input  wire [31:0] reg_val,
  input  wire        use_const,
  input  wire        const_signed,
  output wire [31:0] value
);
  wire [4:0] cst;
  assign cst = reg_val[4:0];
  // signed constants sign extend; unsigned ones zero extend
  assign value = !use_const ? reg_val :
                 const_signed ? {{27{cst[4]}}, cst} : {27'h0000000, cst};
endmodule
`default_nettype wire

// *** rtl/addr_scale.v ***
// address offset scaling for halfword and word address forms
`timescale 1ns/100ps
`default_nettype none
module addr_scale (
  input  wire [31:0] offset,
  input  wire [1:0]  shift,
  input  wire        enable,
  output wire [31:0] scaled
);
  // shift only when the caller says the scaling applies
  assign scaled = !enable ? offset :
                  (shift == 2'h2) ? {offset[29:0], 2'h0} :
                  (shift == 2'h1) ? {offset[30:0], 1'h0} : offset;
endmodule
`default_nettype wire

// *** rtl/sub_store_unit.v ***
// subtract and word store execute unit with Avalon-MM register access
// Contract
// - y bit picks low or high page base
// - fifteen bit offset shifted two then added
// - long offset store is always linear
// - store writes all 32 source bits
// - s bit only flags the source in status; data is always op B
// - long offset store only on second data unit
// - logic/shift subtract is first minus second
// - data unit subtract is first minus second
// - logic/shift signed constant either operand
// - data unit constant only second, unsigned
// - byte address subtract unscaled
// - halfword address subtract shifts one if circular
// - word address subtract shifts two if circular
// - circular only for eligible base and mode
// - conditional subtract shift for division step
// - every subtract finishes in one execute cycle
// - post modes store old base, write back new
// - pre and offset modes store computed address
`timescale 1ns/100ps
`default_nettype none
`include "sub_store_defs.vh"
module sub_store_unit (
  input  wire        clk,
  input  wire        nrst,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg         mem_we,
  output reg  [31:0] wb_base,
  output reg         wb_we
);
  // ****************************************************************
  // software visible registers
  // ****************************************************************
  reg [31:0] opcode_reg;
  reg [31:0] op_a_reg;
  reg [31:0] op_b_reg;
  reg [31:0] base_lo_reg;
  reg [31:0] base_hi_reg;
  reg [31:0] amr_reg;
  reg [31:0] res_lo_reg;
  reg [7:0]  res_hi_reg;
  reg [5:0]  status_reg;
  reg        rd_pend_reg;

  // byte lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    begin
      merge = {be[3] ? nw[31:24] : old[31:24], be[2] ? nw[23:16] : old[23:16],
               be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // ****************************************************************
  // opcode field decode
  // ****************************************************************
  wire [3:0]  op;
  wire [2:0]  amode;
  wire [14:0] ofs15;
  wire        circ;
  assign op    = opcode_reg[`F_OP_HI:`F_OP_LO];
  assign amode = opcode_reg[`F_MODE_HI:`F_MODE_LO];
  assign ofs15 = opcode_reg[`F_OFS15_HI:`F_OFS15_LO];
  // circular applies only when the base is eligible and mode register enables it
  assign circ  = opcode_reg[`F_CIRC_BASE] && (amr_reg != `RST_ZERO);

  wire is_d_unit;
  assign is_d_unit = (op == `OP_SUB_D) || (op == `OP_SUBA_B) ||
                     (op == `OP_SUBA_H) || (op == `OP_SUBA_W);

  // ****************************************************************
  // operand preparation
  // ****************************************************************
  wire [31:0] first_operand;
  wire [31:0] second_operand;
  wire        first_const;
  // data units never take a constant first operand in this position
  assign first_const = opcode_reg[`F_CONST_A] && !is_d_unit;
  operand_select u_first (
    .reg_val      (op_a_reg),
    .use_const    (first_const),
    .const_signed (1'b1),
    .value        (first_operand)
  );
  operand_select u_second (
    .reg_val      (op_b_reg),
    .use_const    (opcode_reg[`F_CONST_B]),
    .const_signed (!is_d_unit),
    .value        (second_operand)
  );

  // halfword and word address forms scale only in circular mode
  wire [1:0]  scale_sh;
  wire [31:0] scaled_first;
  assign scale_sh = (op == `OP_SUBA_W) ? 2'h2 : (op == `OP_SUBA_H) ? 2'h1 : 2'h0;
  addr_scale u_scale (
    .offset (second_operand),
    .shift  (scale_sh),
    .enable (circ),
    .scaled (scaled_first)
  );

  // ****************************************************************
  // arithmetic
  // ****************************************************************
  wire [31:0] diff_ls;
  wire [39:0] diff_long;
  wire [31:0] diff_d;
  wire [31:0] diff_a;
  wire [32:0] diff_c;
  wire [31:0] cond_subtract_shift_op_val;
  assign diff_ls   = first_operand - second_operand;
  // long form sign extends both operands to 40 bits
  assign diff_long = {{8{first_operand[31]}}, first_operand} -
                     {{8{second_operand[31]}}, second_operand};
  assign diff_d    = first_operand - second_operand;
  // byte form passes scale 0, so the second operand stays unscaled
  assign diff_a    = first_operand - scaled_first;
  // unsigned compare through a 33-bit difference
  assign diff_c    = {1'b0, first_operand} - {1'b0, second_operand};
  assign cond_subtract_shift_op_val  = diff_c[32] ? {first_operand[30:0], 1'b0} :
                     {diff_c[30:0], 1'b1};

  // ****************************************************************
  // store address generation
  // ****************************************************************
  wire [31:0] long_base;
  wire [31:0] long_addr;
  wire [31:0] reg_ofs;
  wire [31:0] sum_up;
  wire [31:0] sum_dn;
  wire        mode_dec;
  wire        mode_post;
  reg  [31:0] st_addr;
  reg  [31:0] new_base;
  assign long_base = opcode_reg[`F_SIDE_Y] ? base_hi_reg : base_lo_reg;
  // always linear: circular settings are never looked at here
  assign long_addr = long_base + {15'h0000, ofs15, 2'h0};
  assign reg_ofs   = {second_operand[29:0], 2'h0};
  assign sum_up    = first_operand + reg_ofs;
  assign sum_dn    = first_operand - reg_ofs;
  assign mode_dec  = (amode == `AM_POST_DEC) || (amode == `AM_PRE_DEC) ||
                     (amode == `AM_NEG_OFS);
  assign mode_post = (amode == `AM_POST_INC) || (amode == `AM_POST_DEC);

  // register form: post modes send the old base, others the sum
  always @* begin
    new_base = mode_dec ? sum_dn : sum_up;
    if (mode_post)
      st_addr = first_operand;
    else
      st_addr = new_base;
  end

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire        exec_go;
  assign exec_go = avs_write && (avs_address == `OFS_CTRL) && avs_writedata[0];

  reg [31:0] rd_mux;
  always @* begin
    case (avs_address)
      `OFS_OPCODE:   rd_mux = opcode_reg;
      `OFS_OP_A:     rd_mux = op_a_reg;
      `OFS_OP_B:     rd_mux = op_b_reg;
      `OFS_BASE_LO:  rd_mux = base_lo_reg;
      `OFS_BASE_HI:  rd_mux = base_hi_reg;
      `OFS_AMR:      rd_mux = amr_reg;
      `OFS_RES_LO:   rd_mux = res_lo_reg;
      `OFS_RES_HI:   rd_mux = {{24{res_hi_reg[7]}}, res_hi_reg};
      `OFS_MEM_ADDR: rd_mux = mem_addr;
      `OFS_MEM_DATA: rd_mux = mem_wdata;
      `OFS_WB_BASE:  rd_mux = wb_base;
      `OFS_STATUS:   rd_mux = {26'h0000000, status_reg};
      default:       rd_mux = `RST_ZERO;
    endcase
  end

  // ****************************************************************
  // bus slave: writes and reads both answer one cycle later
  // ****************************************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `RST_ZERO;
      rd_pend_reg     <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
      if (avs_read && !rd_pend_reg) begin
        rd_pend_reg     <= 1'b1;
        avs_readdata    <= rd_mux;
        avs_waitrequest <= 1'b0;
      end else if (avs_write && avs_waitrequest && !rd_pend_reg) begin
        avs_waitrequest <= 1'b0;
        rd_pend_reg     <= 1'b1;
      end else begin
        rd_pend_reg <= 1'b0;
      end
    end
  end

  wire wr_take;
  assign wr_take = avs_write && !avs_waitrequest;

  // configuration registers, written at the accepting edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opcode_reg  <= `RST_ZERO;
      op_a_reg    <= `RST_ZERO;
      op_b_reg    <= `RST_ZERO;
      base_lo_reg <= `RST_ZERO;
      base_hi_reg <= `RST_ZERO;
      amr_reg     <= `RST_ZERO;
    end else if (wr_take) begin
      case (avs_address)
        `OFS_OPCODE:  opcode_reg  <= merge(opcode_reg, avs_writedata, avs_byteenable);
        `OFS_OP_A:    op_a_reg    <= merge(op_a_reg, avs_writedata, avs_byteenable);
        `OFS_OP_B:    op_b_reg    <= merge(op_b_reg, avs_writedata, avs_byteenable);
        `OFS_BASE_LO: base_lo_reg <= merge(base_lo_reg, avs_writedata, avs_byteenable);
        `OFS_BASE_HI: base_hi_reg <= merge(base_hi_reg, avs_writedata, avs_byteenable);
        `OFS_AMR:     amr_reg     <= merge(amr_reg, avs_writedata, avs_byteenable);
        default:      amr_reg     <= amr_reg;
      endcase
    end
  end

  // ****************************************************************
  // execute: at the edge that accepts the go write
  // ****************************************************************
  wire go_now;
  wire pred_ok;
  wire is_store;
  wire unit_bad;
  wire align_bad;
  assign go_now    = wr_take && exec_go;
  assign pred_ok   = opcode_reg[`F_PRED];
  assign is_store  = (op == `OP_STW_REG) || (op == `OP_STW_LONG);
  assign unit_bad  = (op == `OP_STW_LONG) && !opcode_reg[`F_UNIT_D2];
  // misaligned addresses are the caller's fault; flagged, not stored
  assign align_bad = is_store &&
                     (((op == `OP_STW_LONG) ? long_addr[1:0] : st_addr[1:0]) != 2'h0);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_lo_reg <= `RST_ZERO;
      res_hi_reg <= 8'h00;
      status_reg <= 6'h00;
      mem_addr   <= `RST_ZERO;
      mem_wdata  <= `RST_ZERO;
      mem_we     <= 1'b0;
      wb_base    <= `RST_ZERO;
      wb_we      <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      wb_we  <= 1'b0;
      if (go_now) begin
        status_reg <= 6'h01;
        if (!pred_ok) begin
          status_reg[`ST_SKIPPED] <= 1'b1;
        end else if (unit_bad) begin
          status_reg[`ST_UNIT_ERR] <= 1'b1;
        end else if (align_bad) begin
          status_reg[`ST_ALIGN_ERR] <= 1'b1;
        end else begin
          case (op)
            `OP_SUB_LS: begin
              res_lo_reg <= diff_ls;
              res_hi_reg <= 8'h00;
            end
            `OP_SUB_LONG: begin
              res_lo_reg <= diff_long[31:0];
              res_hi_reg <= diff_long[39:32];
            end
            `OP_SUB_D: begin
              res_lo_reg <= diff_d;
              res_hi_reg <= 8'h00;
            end
            `OP_SUBA_B, `OP_SUBA_H, `OP_SUBA_W: begin
              res_lo_reg <= diff_a;
              res_hi_reg <= 8'h00;
            end
            `OP_COND_SUBTRACT_SHIFT_OP: begin
              res_lo_reg <= cond_subtract_shift_op_val;
              res_hi_reg <= 8'h00;
            end
            `OP_STW_REG: begin
              mem_addr   <= st_addr;
              mem_wdata  <= op_b_reg;
              mem_we     <= 1'b1;
              wb_base    <= new_base;
              wb_we      <= mode_post || (amode == `AM_PRE_INC) || (amode == `AM_PRE_DEC);
              status_reg[`ST_STORED] <= 1'b1;
              status_reg[`ST_SRC_B]  <= opcode_reg[`F_SIDE_S];
            end
            `OP_STW_LONG: begin
              mem_addr   <= long_addr;
              mem_wdata  <= op_b_reg;
              mem_we     <= 1'b1;
              status_reg[`ST_STORED] <= 1'b1;
              status_reg[`ST_SRC_B]  <= opcode_reg[`F_SIDE_S];
            end
            default: res_lo_reg <= res_lo_reg;
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** testbench/sub_store_unit_properties.sv ***
// port checker for the subtract and word store unit
`timescale 1ns/100ps
`default_nettype none
module sub_store_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_we,
  input wire logic        wb_we
);
  // ****
  // timing of bus answers and stores
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // a write taken by the unit; only this may launch an operation
  wire logic wr_ok = avs_write && !avs_waitrequest;
  property p_wlow; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wlow: assert property (p_wlow) else $error("wait low twice");
  property p_wask; !avs_waitrequest |-> avs_read || avs_write; endproperty
  a_wask: assert property (p_wask) else $error("wait low unasked");
  property p_ans; avs_read || avs_write |-> ##[0:3] !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_st; mem_we |-> $past(wr_ok) ##1 !mem_we; endproperty
  a_st: assert property (p_st) else $error("store timing");
  property p_wb; wb_we |-> mem_we && $past(wr_ok); endproperty
  a_wb: assert property (p_wb) else $error("writeback timing");
  property p_wb1; wb_we |=> !wb_we; endproperty
  a_wb1: assert property (p_wb1) else $error("writeback long");
  property p_al; mem_we |-> mem_addr[1:0] == 2'h0; endproperty
  a_al: assert property (p_al) else $error("store unaligned");
  property p_rdq; avs_read && !avs_waitrequest |=> !mem_we && !wb_we; endproperty
  a_rdq: assert property (p_rdq) else $error("read caused store");
  c_st: cover property (mem_we);
  c_wb: cover property (wb_we);
  c_rd: cover property (avs_read && !avs_waitrequest);
endmodule
bind sub_store_unit sub_store_checker u_chk (.clk(clk), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr),
  .mem_we(mem_we), .wb_we(wb_we));
`default_nettype wire

// *** testbench/data_mem_model.sv ***
// data memory model on the store port of the unit
`timescale 1ns/100ps
`default_nettype none
module data_mem_model (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_we
);
  // ****
  // store sink
  // ****
  logic [31:0] last_addr;
  logic [31:0] last_data;
  int          n_store;
  // the port has no stall, so each pulse is one whole word taken
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_addr <= 32'h0;
      last_data <= 32'h0;
      n_store <= 0;
    end else if (mem_we) begin
      last_addr <= mem_addr;
      last_data <= mem_wdata;
      n_store <= n_store + 1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/subtract_and_word_store_unit_tb_top.sv ***
// self-checking bench for the subtract and word store unit
`timescale 1ns/100ps
`default_nettype none
`include "sub_store_defs.vh"
module subtract_and_word_store_unit_tb_top;
  // ****
  // bench
  // ****
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] seed = 32'h322D;
  logic [31:0] rd, a, b, e;
  logic [39:0] l;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          wb_cnt = 0;
  int          n0, w0;
  wire logic [31:0] avs_readdata, mem_addr, mem_wdata, wb_base;
  wire logic        avs_waitrequest, mem_we, wb_we;
  sub_store_unit u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .wb_base(wb_base), .wb_we(wb_we));
  data_mem_model u_mem (.clk(clk), .nrst(nrst), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we));
  // clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  // writebacks counted: offset modes must leave the base alone
  always @(posedge clk) begin
    if (wb_we === 1'b1) wb_cnt <= wb_cnt + 1;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction
  function automatic logic [31:0] mk(input logic [3:0] op, input logic [6:0] fl,
                                     input logic [2:0] md, input logic [14:0] ofs);
    return {1'b0, ofs, 2'h0, md, fl, op};
  endfunction
  function automatic logic [31:0] exp_sub(input logic [3:0] op, input logic [31:0] x, y,
                                          input logic c);
    logic [31:0] d;
    d = x - y;
    if (op == `OP_SUBA_H && c) d = x - (y << 1);
    if (op == `OP_SUBA_W && c) d = x - (y << 2);
    if (op == `OP_COND_SUBTRACT_SHIFT_OP) d = x >= y ? {d[30:0], 1'b1} : {x[30:0], 1'b0};
    return d;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one bus transfer; waitrequest and read data are looked at on rising edges only,
  // and the request is dropped at the very edge that accepts it
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d,
                     input logic [3:0] be);
    int n = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      $display("unexpected at %0t: bus hang", $time);
      results();
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d, 4'hF);
  endtask
  task automatic rg(input logic [3:0] ad);
    bus(1'b0, ad, 32'h0, 4'h0);
  endtask
  task automatic exec(input logic [31:0] opw, input logic [31:0] x, y);
    wr(`OFS_OPCODE, opw);
    wr(`OFS_OP_A, x);
    wr(`OFS_OP_B, y);
    wr(`OFS_CTRL, 32'h1);
    rg(`OFS_RES_LO);
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    check({31'h0, avs_waitrequest}, 32'h1);
    rg(`OFS_STATUS);
    check(rd, 32'h0);
    rg(4'hE);
    check(rd, 32'h0);
    $display("done: reset");
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 7; k++) begin
        a = rnd();
        b = k == 6 ? a >> 3 : rnd() >> (k == 6 ? 2 : 0);
        e = {31'h0, seed[4]};
        wr(`OFS_AMR, e);
        exec(mk(k[3:0], {seed[9], 6'h20}, 3'h0, 15'h0), k == 6 ? a >> 2 : a, b);
        check(rd, exp_sub(k[3:0], k == 6 ? a >> 2 : a, b, seed[9] && e[0]));
        l = {{8{a[31]}}, a} - {{8{b[31]}}, b};
        rg(`OFS_RES_HI);
        if (k == 1) check(rd, {{24{l[39]}}, l[39:32]});
      end
    end
    $display("done: subtracts");
    exec(mk(`OP_SUB_LS, 7'h22, 3'h0, 15'h0), 32'h100, 32'h1F);
    check(rd, 32'h101);
    exec(mk(`OP_SUB_LS, 7'h21, 3'h0, 15'h0), 32'h1E, 32'h5);
    check(rd, 32'hFFFFFFF9);
    exec(mk(`OP_SUB_D, 7'h22, 3'h0, 15'h0), 32'h100, 32'hFFFFFF1F);
    check(rd, 32'hE1);
    exec(mk(`OP_SUB_LS, 7'h00, 3'h0, 15'h0), 32'h7, 32'h1);
    check(rd, 32'hE1);
    rg(`OFS_STATUS);
    check({31'h0, rd[`ST_SKIPPED]}, 32'h1);
    wr(`OFS_OPCODE, mk(`OP_SUB_LS, 7'h20, 3'h0, 15'h0));
    wr(`OFS_OP_A, 32'hFFFFFFFF);
    bus(1'b1, `OFS_OP_A, 32'h12345678, 4'h3);
    wr(`OFS_CTRL, 32'h1);
    rg(`OFS_RES_LO);
    check(rd, 32'hFFFF5677);
    $display("done: constants");
    exec(mk(`OP_COND_SUBTRACT_SHIFT_OP, 7'h20, 3'h0, 15'h0), 32'h21A31, 32'h1F63F);
    check(rd, 32'h47E5);
    exec(mk(`OP_COND_SUBTRACT_SHIFT_OP, 7'h20, 3'h0, 15'h0), 32'h125A, 32'h1F12);
    check(rd, 32'h24B4);
    wr(`OFS_BASE_LO, 32'h1000);
    wr(`OFS_BASE_HI, 32'h80000);
    wr(`OFS_AMR, 32'h1);
    for (int y = 0; y < 2; y++) begin
      b = rnd();
      n0 = u_mem.n_store;
      exec(mk(`OP_STW_LONG, y ? 7'h7C : 7'h70, 3'h0, 15'h7FFF), 32'h0, b);
      check(u_mem.last_addr, (y ? 32'h80000 : 32'h1000) + 32'h1FFFC);
      check(u_mem.last_data, b);
      check(32'(u_mem.n_store - n0), 32'h1);
      rg(`OFS_STATUS);
      check({31'h0, rd[`ST_SRC_B]}, 32'(y));
    end
    n0 = u_mem.n_store;
    exec(mk(`OP_STW_LONG, 7'h20, 3'h0, 15'h4), 32'h0, 32'h5);
    check(32'(u_mem.n_store - n0), 32'h0);
    rg(`OFS_STATUS);
    check({31'h0, rd[`ST_UNIT_ERR]}, 32'h1);
    for (int m = 0; m < 6; m++) begin
      a = rnd() & 32'h0000FFFC;
      b = {27'h0, seed[20:16]};
      e = m[0] ? a - (b << 2) : a + (b << 2);
      n0 = u_mem.n_store;
      w0 = wb_cnt;
      exec(mk(`OP_STW_REG, 7'h20, m[2:0], 15'h0), a, b);
      check(u_mem.last_addr, m < 2 ? a : e);
      check(u_mem.last_data, b);
      check(32'(wb_cnt - w0), m < 4 ? 32'h1 : 32'h0);
      if (m < 4) check(wb_base, e);
      rg(`OFS_WB_BASE);
      if (m < 4) check(rd, e);
    end
    $display("done: stores");
    results();
  end
endmodule
`default_nettype wire
